// ===== include/dsto_map.svh
// Purpose: Constants for the dual channel safe torque off block
// Assumes: 250 MHz core clock
// Notes: Times kept in their own unit, cycle counts derived
`ifndef DSTO_MAP_SVH
`define DSTO_MAP_SVH

`define DSTO_CLK_MHZ 250
`define DSTO_FILT_US 500
`define DSTO_FILT_CYC ((`DSTO_FILT_US * `DSTO_CLK_MHZ) + 1)
`define DSTO_OFF_MAX_MS 20
`define DSTO_OFF_MAX_CYC (`DSTO_OFF_MAX_MS * 1000 * `DSTO_CLK_MHZ)
`define DSTO_MISM_S 10
`define DSTO_MISM_CYC (`DSTO_MISM_S * 1000 * 1000 * `DSTO_CLK_MHZ)

`define DSTO_REG_STATUS 4'h0
`define DSTO_REG_MASK 4'h1
`define DSTO_REG_CTRL 4'h2
`define DSTO_REG_MON 4'h3

`define DSTO_IRQ_BLOCK 0
`define DSTO_IRQ_MISM 1
`define DSTO_IRQ_CHG 2
`define DSTO_IRQ_W 3

`define DSTO_CTRL_DB 0
`define DSTO_CTRL_BRK_DLY_LSB 8
`define DSTO_CTRL_BRK_DLY_W 16
`define DSTO_CTRL_RST 32'h0000_0000
`define DSTO_MASK_RST 3'h0

`endif

// ===== include/dsto_pkg.sv
// Purpose: Types for the dual channel safe torque off block
// Assumes: Constants come from dsto_map.svh
// Notes: None
package dsto_pkg;
   typedef enum logic [1:0] {
      DSTO_RUN = 2'b00,
      DSTO_IDLE = 2'b01,
      DSTO_BLOCKED = 2'b10
   } dsto_state_e;

   typedef struct packed {
      logic power_on_command;
      logic power_off_command;
      logic utility_active;
   } dsto_cmd_s;

   typedef struct packed {
      logic motor_power;
      logic drive_ready;
      logic holding_brake_out;
      logic dynamic_brake;
      logic fault_out;
      logic feedback_monitor_out;
      logic emergency_stop_flag;
      logic blocked_display;
      logic utility_locked;
   } dsto_out_s;
endpackage : dsto_pkg

// ===== core/dsto_filter.sv
// Purpose: Synchroniser and OFF-pulse filter for one safety request channel
// Assumes: Raw input is asynchronous to clk_i; high means channel ON
// Notes: OFF is accepted only after it lasts longer than the filter time
`timescale 1ns/1ps
`include "dsto_map.svh"
module dsto_filter (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic raw_i,
   output logic on_o
);
   localparam int unsigned FILT = `DSTO_FILT_CYC;
   logic meta_q;
   logic sync_q;
   logic [17:0] cnt_q;

   // Two stage synchroniser; inputs idle as OFF until proven ON
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= raw_i;
         sync_q <= meta_q;
      end
   end

   // Short OFF pulses are swallowed; ON is taken at once
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= 18'h0_0000;
         on_o <= 1'b0;
      end else if (sync_q) begin
         cnt_q <= 18'h0_0000;
         on_o <= 1'b1;
      end else if (cnt_q >= 18'(FILT - 1)) begin
         on_o <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 18'h0_0001;
      end
   end
endmodule : dsto_filter

// ===== core/dsto_core.sv
// Purpose: Dual channel safe torque off sequencing, outputs and registers
// Assumes: Command pulses one cycle long; register port per house bus
// Notes: Filtered OFF reaches power removal well inside the 20 ms bound
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "dsto_map.svh"
// Functional notes
// - Two redundant channels; ON means run, OFF requests current shut-off.
// - Both channels OFF removes motor power within 20 ms.
// - OFF lasting 0.5 ms or less is ignored entirely.
// - Blocking stays active while any utility mode runs. Here power-off with both channels ON still leaves blocked with utility active.
// - Utility motion stays locked after channels return; exit and re-enter.
// - In hard-blocked state power-on is rejected and drive-ready is off.
// - Drive-ready only in idle blocked state with both channels ON.
// - Holding brake released at once on block, skipping the brake delay.
// - Dynamic brake used on block when stop method selects it.
// - Hard-blocked state alone never asserts the fault output.
// - Feedback monitor ON only when both channels are OFF.
// - Feedback monitor follows channel changes within 20 ms.
// - Each channel state is readable in the safety input monitor.
// - Both channels OFF shows blocked code and keeps motor unpowered.
// - One channel OFF for 10 s without the other raises mismatch alarm.
// - Emergency stop flag reads 1 while blocking is active.
// - Leave hard-blocked only via power-off with both channels ON.
module dsto_core #(
   parameter int unsigned MISM_CYC = `DSTO_MISM_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic safety_request_a_i,
   input wire logic safety_request_b_i,
   input dsto_pkg::dsto_cmd_s cmd_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output dsto_pkg::dsto_out_s out_o,
   output logic input_mismatch_alarm_o,
   output logic irq_o
);
   logic on_a;
   logic on_b;
   dsto_pkg::dsto_state_e state_q;
   dsto_pkg::dsto_state_e state_d;
   logic any_off;
   logic both_off;
   logic [31:0] mism_cnt_q;
   logic [31:0] ctrl_q;
   logic [`DSTO_IRQ_W-1:0] status_q;
   logic [`DSTO_IRQ_W-1:0] mask_q;
   logic [`DSTO_IRQ_W-1:0] evt;
   logic [1:0] prev_q;
   logic blk_prev_q;
   logic mism_prev_q;

   // Filtered, synchronised channel views
   dsto_filter u_filt_a (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .raw_i(safety_request_a_i),
      .on_o(on_a)
   );
   dsto_filter u_filt_b (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .raw_i(safety_request_b_i),
      .on_o(on_b)
   );

   // Either channel OFF blocks, whatever the drive is doing
   assign any_off = !on_a || !on_b;
   assign both_off = !on_a && !on_b;

   always_comb begin
      state_d = state_q;
      case (state_q)
         dsto_pkg::DSTO_RUN: begin
            if (any_off) begin
               state_d = dsto_pkg::DSTO_BLOCKED;
            end else if (cmd_i.power_off_command) begin
               state_d = dsto_pkg::DSTO_IDLE;
            end
         end
         dsto_pkg::DSTO_IDLE: begin
            if (any_off) begin
               state_d = dsto_pkg::DSTO_BLOCKED;
            end else if (cmd_i.power_on_command) begin
               state_d = dsto_pkg::DSTO_RUN;
            end
         end
         dsto_pkg::DSTO_BLOCKED: begin
            // Power-on is ignored here; only power-off with both ON exits
            if (!any_off && cmd_i.power_off_command) begin
               state_d = dsto_pkg::DSTO_IDLE;
            end
         end
         default: begin
            state_d = dsto_pkg::DSTO_BLOCKED;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= dsto_pkg::DSTO_BLOCKED;
      end else begin
         state_q <= state_d;
      end
   end

   // Power stage and brake outputs, registered
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_o.motor_power <= 1'b0;
         out_o.drive_ready <= 1'b0;
         out_o.holding_brake_out <= 1'b0;
         out_o.dynamic_brake <= 1'b0;
         out_o.emergency_stop_flag <= 1'b0;
         out_o.blocked_display <= 1'b0;
         out_o.feedback_monitor_out <= 1'b0;
         out_o.utility_locked <= 1'b0;
         out_o.fault_out <= 1'b0;
      end else begin
         // Brake release and power removal are immediate; brake delay not used
         out_o.motor_power <= (state_d == dsto_pkg::DSTO_RUN) && !any_off;
         out_o.holding_brake_out <= (state_d == dsto_pkg::DSTO_RUN) && !any_off;
         out_o.dynamic_brake <= (state_d == dsto_pkg::DSTO_BLOCKED) &&
            ctrl_q[`DSTO_CTRL_DB];
         out_o.drive_ready <= (state_d == dsto_pkg::DSTO_IDLE) && !any_off;
         out_o.emergency_stop_flag <= (state_d == dsto_pkg::DSTO_BLOCKED);
         out_o.blocked_display <= both_off;
         // Truth table: ON only for both OFF, one cycle after filtering
         out_o.feedback_monitor_out <= both_off;
         // Utility motion latches off once blocked until the mode is left
         out_o.utility_locked <= cmd_i.utility_active && (out_o.utility_locked || any_off);
         // Fault output follows the mismatch alarm only, never the block itself
         out_o.fault_out <= input_mismatch_alarm_o;
      end
   end

   // Mismatch timer: one channel OFF alone too long
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mism_cnt_q <= 32'h0000_0000;
         input_mismatch_alarm_o <= 1'b0;
      end else if (on_a == on_b) begin
         mism_cnt_q <= 32'h0000_0000;
      end else if (mism_cnt_q >= 32'(MISM_CYC - 1)) begin
         input_mismatch_alarm_o <= 1'b1;
      end else begin
         mism_cnt_q <= mism_cnt_q + 32'h0000_0001;
      end
   end

   // Event edges for the sticky status
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_q <= 2'h0;
         blk_prev_q <= 1'b1;
         mism_prev_q <= 1'b0;
      end else begin
         prev_q <= {on_b, on_a};
         blk_prev_q <= (state_q == dsto_pkg::DSTO_BLOCKED);
         mism_prev_q <= input_mismatch_alarm_o;
      end
   end

   always_comb begin
      evt = '0;
      evt[`DSTO_IRQ_BLOCK] = (state_q == dsto_pkg::DSTO_BLOCKED) && !blk_prev_q;
      evt[`DSTO_IRQ_MISM] = input_mismatch_alarm_o && !mism_prev_q;
      evt[`DSTO_IRQ_CHG] = (prev_q != {on_b, on_a});
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_q <= '0;
      end else if (wr_i && addr_i == `DSTO_REG_STATUS) begin
         status_q <= (status_q & ~wdata_i[`DSTO_IRQ_W-1:0]) | evt;
      end else begin
         status_q <= status_q | evt;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mask_q <= `DSTO_MASK_RST;
         ctrl_q <= `DSTO_CTRL_RST;
      end else if (wr_i) begin
         if (addr_i == `DSTO_REG_MASK) begin
            mask_q <= wdata_i[`DSTO_IRQ_W-1:0];
         end else if (addr_i == `DSTO_REG_CTRL) begin
            // Only the stop method bit and the brake delay field are kept
            ctrl_q <= wdata_i & 32'h00FF_FF01;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_q & mask_q);
      end
   end

   // Read data in the cycle after the strobe only
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (!rd_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (addr_i == `DSTO_REG_STATUS) begin
         rdata_o <= {29'h0, status_q};
      end else if (addr_i == `DSTO_REG_MASK) begin
         rdata_o <= {29'h0, mask_q};
      end else if (addr_i == `DSTO_REG_CTRL) begin
         rdata_o <= ctrl_q;
      end else if (addr_i == `DSTO_REG_MON) begin
         // Channel view, state, stop flag and alarm
         rdata_o <= {24'h0, input_mismatch_alarm_o, state_q == dsto_pkg::DSTO_BLOCKED,
            both_off, state_q, 1'b0, on_b, on_a};
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end
endmodule : dsto_core

// ===== tb/dsto_core_monitor.sv
// Purpose: Port-level assertions for the safe torque off core
// Assumes: Single clock domain, async active-low reset
// Notes: Blocked means filtered both-OFF, seen through feedback_monitor_out
`timescale 1ns/1ps
module dsto_core_monitor (
   input wire logic clk_i,
   input wire logic nrst_i,
   input dsto_pkg::dsto_cmd_s cmd_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input dsto_pkg::dsto_out_s out_o,
   input wire logic input_mismatch_alarm_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_blocked;
      out_o.feedback_monitor_out;
   endsequence
   sequence s_alarm_rise;
      $rose(input_mismatch_alarm_o);
   endsequence
   a_ready_idle_only: assert property (out_o.drive_ready |-> !out_o.motor_power)
      else $error("drive ready while motor powered");
   a_block_unpowered: assert property (
      s_blocked |-> !out_o.motor_power && !out_o.holding_brake_out)
      else $error("power or brake on while blocked");
   a_block_flags: assert property (
      s_blocked |-> out_o.emergency_stop_flag && out_o.blocked_display)
      else $error("stop flag or display missing while blocked");
   a_no_block_fault: assert property (out_o.fault_out |-> input_mismatch_alarm_o)
      else $error("fault output without mismatch alarm");
   a_power_on_refused: assert property (cmd_i.power_on_command && !out_o.drive_ready
      && !out_o.motor_power |=> !out_o.motor_power)
      else $error("power on accepted while not ready");
   a_alarm_sticky: assert property (input_mismatch_alarm_o |=> input_mismatch_alarm_o)
      else $error("mismatch alarm dropped");
   a_fault_follows: assert property (s_alarm_rise |=> out_o.fault_out)
      else $error("fault output late after alarm");
   a_read_data_slot: assert property (rdata_o != 32'h0000_0000 |-> $past(rd_i))
      else $error("read data outside its slot");
   a_lock_holds: assert property (out_o.utility_locked && cmd_i.utility_active
      |=> out_o.utility_locked)
      else $error("utility lock cleared while mode active");
endmodule : dsto_core_monitor

bind dsto_core dsto_core_monitor dsto_core_monitor_i (.clk_i(clk_i), .nrst_i(nrst_i),
   .cmd_i(cmd_i), .rd_i(rd_i), .rdata_o(rdata_o), .out_o(out_o),
   .input_mismatch_alarm_o(input_mismatch_alarm_o));

// ===== tb/dsto_safety_unit.sv
// Purpose: Behavioural safety unit driving both request channels
// Assumes: Guard open drops A at once and B after a skew
// Notes: Test pulse forces both OFF, as unit self-test pulses do
`timescale 1ns/1ps
module dsto_safety_unit #(
   parameter int unsigned SKEW_CYC = 400
) (
   input wire logic clk_i,
   input wire logic guard_open_i,
   input wire logic test_pulse_i,
   input wire logic feedback_i,
   output logic req_a_o,
   output logic req_b_o,
   output logic fail_o
);
   logic a_q = 1'b1;
   logic b_q = 1'b1;
   int unsigned cnt_q = 0;
   initial fail_o = 1'b0;
   always @(posedge clk_i) begin
      if (guard_open_i) begin
         a_q <= 1'b0;
         if (cnt_q < SKEW_CYC) cnt_q <= cnt_q + 1;
         else b_q <= 1'b0;
      end else if (!a_q || !b_q) begin
         cnt_q <= 0;
         // Reset withheld unless the drive confirms its blocked state
         if (feedback_i) begin
            a_q <= 1'b1;
            b_q <= 1'b1;
         end else fail_o <= 1'b1;
      end
   end
   assign req_a_o = a_q & ~test_pulse_i;
   assign req_b_o = b_q & ~test_pulse_i;
endmodule : dsto_safety_unit

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the safe torque off core
// Assumes: Mismatch time shortened to 200 cycles; OFF filter fixed
// Notes: Long OFF waits dominate the run time
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic [3:0] a; logic [31:0] e;} dsto_row_s;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic guard = 1'b0;
   logic tpulse = 1'b0;
   logic req_a, req_b, fail, alarm, irq;
   dsto_pkg::dsto_cmd_s cmd = '0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata, rv;
   dsto_pkg::dsto_out_s out;
   int err_count = 0;
   int check_count = 0;
   int n;
   dsto_row_s rows [3] = '{'{4'h1, 32'h0000_0007}, '{4'hF, 32'h0000_0000},
      '{4'h2, 32'h00FF_FF01}};
   always #2 clk_i = ~clk_i;
   dsto_safety_unit dsto_safety_unit_i (.clk_i(clk_i), .guard_open_i(guard),
      .test_pulse_i(tpulse), .feedback_i(out.feedback_monitor_out),
      .req_a_o(req_a), .req_b_o(req_b), .fail_o(fail));
   dsto_core #(.MISM_CYC(200)) dsto_core_i (.clk_i(clk_i), .nrst_i(nrst_i),
      .safety_request_a_i(req_a), .safety_request_b_i(req_b), .cmd_i(cmd),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .out_o(out), .input_mismatch_alarm_o(alarm), .irq_o(irq));
   task automatic tally_and_finish;
      $display("errors=%0d checks=%0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_i);
   endtask : cyc
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [3:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   task automatic pulse(input logic on);
      if (on) cmd.power_on_command <= 1'b1;
      else cmd.power_off_command <= 1'b1;
      @(posedge clk_i);
      cmd.power_on_command <= 1'b0;
      cmd.power_off_command <= 1'b0;
      cyc(3);
   endtask : pulse
   initial begin
      cyc(16);
      nrst_i <= 1'b1;
      cyc(4);
      rreg(4'h1, rv);
      chk(rv, 32'h0000_0000);
      rreg(4'h2, rv);
      chk(rv, 32'h0000_0000);
      foreach (rows[i]) begin
         wreg(rows[i].a, 32'hFFFF_FFFF);
         rreg(rows[i].a, rv);
         chk(rv, rows[i].e);
      end
      chk(32'(out.drive_ready), 32'h0000_0000);
      pulse(1'b1);
      chk(32'(out.motor_power), 32'h0000_0000);
      pulse(1'b0);
      chk(32'(out.drive_ready), 32'h0000_0001);
      pulse(1'b1);
      chk(32'(out), 32'h0000_0140);
      // Exactly 0.5 ms of OFF must pass unnoticed
      tpulse <= 1'b1;
      cyc(125000);
      tpulse <= 1'b0;
      cyc(10);
      chk(32'(out), 32'h0000_0140);
      wreg(4'h0, 32'hFFFF_FFFF);
      cmd.utility_active <= 1'b1;
      guard <= 1'b1;
      n = 0;
      while (out.feedback_monitor_out !== 1'b1) begin
         @(posedge clk_i);
         n++;
         if (n > 125500) begin
            err_count++;
            tally_and_finish();
         end
      end
      chk(32'(n >= 125400), 32'h0000_0001);
      cyc(2);
      chk(32'(out), 32'h0000_003F);
      chk(32'(alarm), 32'h0000_0001);
      rreg(4'h3, rv);
      chk(rv, 32'h0000_00F0);
      rreg(4'h0, rv);
      chk(rv, 32'h0000_0007);
      chk(32'(irq), 32'h0000_0001);
      wreg(4'h1, 32'h0000_0000);
      cyc(2);
      chk(32'(irq), 32'h0000_0000);
      wreg(4'h1, 32'h0000_0007);
      cyc(2);
      chk(32'(irq), 32'h0000_0001);
      wreg(4'h0, 32'hFFFF_FFFF);
      cyc(2);
      chk(32'(irq), 32'h0000_0000);
      guard <= 1'b0;
      cyc(10);
      chk(32'(fail), 32'h0000_0000);
      chk(32'(out.feedback_monitor_out), 32'h0000_0000);
      chk(32'(out.utility_locked), 32'h0000_0001);
      chk(32'(out.drive_ready | out.motor_power), 32'h0000_0000);
      cmd.utility_active <= 1'b0;
      cyc(3);
      chk(32'(out.utility_locked), 32'h0000_0000);
      pulse(1'b0);
      chk(32'(out.drive_ready), 32'h0000_0001);
      tally_and_finish();
   end
endmodule : tb_top
